// ---- pkg/tx_pkg.sv ----
// Shared constants for the transmit retry and status controller
package tx_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] REG_CFG      = 4'h0; // MAC mode and encryption
  localparam logic [3:0] REG_RETRY    = 4'h1; // Application retry count
  localparam logic [3:0] REG_COMPAT   = 4'h2; // Compatibility setting
  localparam logic [3:0] REG_IRQ_STAT = 4'h3; // Sticky event bits, read only
  localparam logic [3:0] REG_IRQ_EN   = 4'h4; // Interrupt enables
  localparam logic [3:0] REG_IRQ_CLR  = 4'h5; // Write one to clear, write only
  localparam logic [3:0] REG_STATE    = 4'h6; // Slot busy bits and ready
  // Field positions
  localparam int CFG_MM_LSB    = 0; // Two-bit MAC mode field
  localparam int CFG_ENC_BIT   = 2; // Encryption enable
  localparam int COMPAT_TX_BIT = 0; // Single-packet compatibility path
  localparam int IRQ_STATUS    = 0; // A status answer was sent
  localparam int IRQ_REJECT    = 1; // A request was too large
  localparam int IRQ_FAIL      = 2; // A request finished without success
  localparam int IRQ_W         = 3;
  // Reset values
  localparam logic [1:0] MM_RST     = 2'h0;
  localparam logic       ENC_RST    = 1'b0;
  localparam logic [7:0] RR_RST     = 8'h00;
  localparam logic [7:0] COMPAT_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  // Payload arithmetic, in bytes
  localparam logic [7:0] PKT_MAX      = 8'h74; // 116
  localparam logic [7:0] ENC_OVH      = 8'h05;
  localparam logic [7:0] LONG_ADDR    = 8'h06;
  localparam logic [7:0] HDR_PLAIN    = 8'h02;
  localparam logic [7:0] HDR_ENC      = 8'h04;
  localparam logic [7:0] COMPAT_ENC   = 8'h5f; // 95
  localparam logic [7:0] COMPAT_PLAIN = 8'h64; // 100
  // Transmit status codes
  localparam logic [7:0] ST_OK      = 8'h00;
  localparam logic [7:0] ST_NOACK   = 8'h01;
  localparam logic [7:0] ST_CCA     = 8'h02;
  localparam logic [7:0] ST_NETACK  = 8'h21;
  localparam logic [7:0] ST_TOO_BIG = 8'h74;
  // Link-level retries per application attempt
  localparam logic [1:0] MAC_RETRIES = 2'h3;
endpackage

// ---- pkg/eng_if.sv ----
// Control and result bundle between the dispatcher and one attempt engine
`timescale 1ns/1ps
interface eng_if;
  logic       start;    // Launch a request, one cycle
  logic       bcast;    // Broadcast destination
  logic       ack_en;   // Request link acknowledgment
  logic       hdr_en;   // Insert application header
  logic       app_en;   // Application retries active
  logic [7:0] frame_id; // Request frame identifier
  logic [7:0] retries;  // Application retry budget
  logic       take;     // Result consumed, one cycle
  logic       busy;     // Engine holds a request
  logic       done;     // Result waiting
  logic [7:0] done_id;  // Identifier of the finished request
  logic [7:0] code;     // Final status code
  modport ctrl (output start, bcast, ack_en, hdr_en, app_en, frame_id, retries, take,
                input  busy, done, done_id, code);
  modport eng  (input  start, bcast, ack_en, hdr_en, app_en, frame_id, retries, take,
                output busy, done, done_id, code);
endinterface

// ---- src/tx_attempt_engine.sv ----
// One transmit slot: link retries, application retries and final status
`timescale 1ns/1ps
module tx_attempt_engine
  import tx_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  eng_if.eng        ctl,
  input  wire logic link_done_in,
  input  wire logic link_acked_in,
  input  wire logic link_cca_fail_in,
  input  wire logic net_ack_in,
  output logic      start_out,
  output logic      ack_req_out,
  output logic      app_hdr_out,
  output logic      bcast_out
);
  typedef enum logic [1:0] {IDLE, SEND, WAIT, DONE} eng_state_t;

  eng_state_t state;   // Slot sequencer
  logic [1:0] link_cnt; // Link retries used in this application attempt
  logic [7:0] app_cnt;  // Application retries used
  logic [7:0] retries_q; // Latched retry budget
  logic       app_en_q; // Latched application retry enable
  logic       link_bad; // Attempt failed at link level
  logic       app_bad;  // Link fine but no end-to-end acknowledgment
  logic       retry_link;
  logic       retry_app;
  logic [7:0] next_code;

  // Classify the result of the attempt now ending
  always_comb begin
    link_bad   = link_cca_fail_in || (ack_req_out && !link_acked_in);
    app_bad    = !link_bad && app_en_q && !net_ack_in;
    retry_link = link_bad && (link_cnt < MAC_RETRIES);
    retry_app  = !retry_link && (link_bad || app_bad)
                 && app_en_q && (app_cnt < retries_q);
    // Busy channel wins the code; application retry mode reports end-to-end failure
    if (link_cca_fail_in) begin
      next_code = ST_CCA;
    end else if (link_bad || app_bad) begin
      next_code = app_en_q ? ST_NETACK : ST_NOACK;
    end else begin
      next_code = ST_OK;
    end
  end

  // Sequencer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE: if (ctl.start) state <= SEND;
        SEND: state <= WAIT;
        WAIT: if (link_done_in) state <= (retry_link || retry_app) ? SEND : DONE;
        DONE: if (ctl.take) state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  // Retry counters; an application retry restarts the link budget
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || (state == IDLE)) begin
      link_cnt <= 2'h0;
      app_cnt  <= 8'h00;
    end else if ((state == WAIT) && link_done_in) begin
      if (retry_link) begin
        link_cnt <= link_cnt + 2'h1;
      end else if (retry_app) begin
        link_cnt <= 2'h0;
        app_cnt  <= app_cnt + 8'h01;
      end
    end
  end

  // Request attributes, held for the whole life of the request
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack_req_out <= 1'b0;
      app_hdr_out <= 1'b0;
      bcast_out   <= 1'b0;
      app_en_q    <= 1'b0;
      retries_q   <= 8'h00;
      ctl.done_id <= 8'h00;
    end else if ((state == IDLE) && ctl.start) begin
      ack_req_out <= ctl.ack_en;
      app_hdr_out <= ctl.hdr_en;
      bcast_out   <= ctl.bcast;
      app_en_q    <= ctl.app_en;
      retries_q   <= ctl.retries;
      ctl.done_id <= ctl.frame_id;
    end
  end

  // One-cycle launch pulse and final code
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      start_out <= 1'b0;
      ctl.code  <= ST_OK;
    end else begin
      start_out <= (state == SEND);
      if ((state == WAIT) && link_done_in && !retry_link && !retry_app) begin
        ctl.code <= next_code;
      end
    end
  end

  assign ctl.busy = (state != IDLE);
  assign ctl.done = (state == DONE);

  link_cap_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state == WAIT) && link_done_in && link_bad && (link_cnt == MAC_RETRIES)
    |=> (state == DONE) || (app_cnt != $past(app_cnt)))
    else $error("link retries exceed three");
  app_cap_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (state != IDLE) |-> (app_cnt <= retries_q) && (app_en_q || app_cnt == 8'h00))
    else $error("application retries exceed budget");
endmodule

// ---- src/tx_retry_status_ctrl.sv ----
// Transmit request dispatcher with payload limits, slots and status reporting
// What this block does
// - Compatibility limits: 95 encrypted, 100 plain.
// - Plain limits 114/108/102; header-less adds two.
// - Encrypted limits 101/95 by destination; header-less adds four.
// - Compat bit 0: single packet, one destination.
// - Otherwise several slots, broadcast beside unicast.
// - Modes 0,3 insert header, duplicate detection.
// - Modes 0,2 request acknowledgment, three retries.
// - Modes 1,3 send unicast without acknowledgment.
// - Broadcast never requests acknowledgment.
// - MAC mode resets to zero.
// - Application retries only with header, three link each.
// - Non-zero frame identifier always gets status.
// - Plain acknowledged: 00 reached, 01 unreachable.
// - Plain unacknowledged: 00 with no retries unless the channel is busy.
// - Busy channel: 02 after three link retries.
// - Header with retries: 00 or 21.
// - Oversized payload answered with status 74.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module tx_retry_status_ctrl
  import tx_pkg::*;
#(
  parameter int SLOTS = 2 // Concurrent transmit slots
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic [3:0]       reg_addr_in,
  input  wire logic [7:0]       reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [7:0]       reg_rdata_out,
  input  wire logic             req_valid_in,
  output logic                  req_ready_out,
  input  wire logic [7:0]       req_frame_id_in,
  input  wire logic [7:0]       req_len_in,
  input  wire logic             req_bcast_in,
  input  wire logic             req_long_src_in,
  input  wire logic             req_long_dst_in,
  output logic      [SLOTS-1:0] tx_start_out,
  output logic      [SLOTS-1:0] tx_ack_req_out,
  output logic      [SLOTS-1:0] tx_app_hdr_out,
  output logic      [SLOTS-1:0] tx_bcast_out,
  input  wire logic [SLOTS-1:0] link_done_in,
  input  wire logic [SLOTS-1:0] link_acked_in,
  input  wire logic [SLOTS-1:0] link_cca_fail_in,
  input  wire logic [SLOTS-1:0] net_ack_in,
  output logic                  stat_valid_out,
  output logic      [7:0]       stat_frame_id_out,
  output logic      [7:0]       stat_code_out,
  output logic                  dup_detect_en_out,
  output logic                  irq_out
);
  import tx_pkg::*;

  localparam int IDX_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;

  // Software settings
  logic [1:0]       mac_mode_sel;    // MAC mode
  logic             enc_on;          // Encryption enable
  logic [7:0]       app_retry_count; // Extra application attempts
  logic [7:0]       compat_cfg;      // Compatibility setting
  logic [IRQ_W-1:0] irq_stat;        // Sticky events
  logic [IRQ_W-1:0] irq_en;          // Event enables

  // Decoded modes
  logic compat_on; // Single-packet path
  logic hdr_on;    // Header inserted
  logic ack_on;    // Unicast acknowledgment requested

  // Dispatch
  logic [7:0]       limit;     // Payload limit of the offered request
  logic             accept;    // Request taken this cycle
  logic             too_big;   // Offered payload over the limit
  logic             launch;    // Accepted and sent to a slot
  logic [SLOTS-1:0] busy_vec;
  logic [SLOTS-1:0] done_vec;
  logic [SLOTS-1:0] sel;       // Slot chosen for the launch
  logic [SLOTS-1:0] take_vec;
  logic             free_any;
  logic [IDX_W-1:0] free_idx;
  logic             slot_ok;
  logic [IDX_W-1:0] chosen;
  logic             done_any;
  logic [IDX_W-1:0] done_idx;
  logic             take_ok;
  logic [7:0]       did [SLOTS];   // Finished identifiers per slot
  logic [7:0]       dcode [SLOTS]; // Finished codes per slot
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] next_irq_stat;
  logic             next_stat_valid;

  assign compat_on = compat_cfg[COMPAT_TX_BIT];
  assign hdr_on    = (mac_mode_sel[0] == mac_mode_sel[1]);
  assign ack_on    = !mac_mode_sel[0];

  // Payload limit for the offered request
  always_comb begin
    if (compat_on) begin
      limit = enc_on ? COMPAT_ENC : COMPAT_PLAIN;
    end else begin
      limit = PKT_MAX;
      // Encryption forces a long source, so the source size stops mattering
      if (enc_on) begin
        limit = limit - ENC_OVH - LONG_ADDR;
      end else if (req_long_src_in) begin
        limit = limit - LONG_ADDR;
      end
      if (req_long_dst_in) begin
        limit = limit - LONG_ADDR;
      end
      if (hdr_on) begin
        limit = limit - (enc_on ? HDR_ENC : HDR_PLAIN);
      end
    end
  end

  // Free slot and finished slot search, lowest index first
  always_comb begin
    free_any = 1'b0;
    free_idx = '0;
    done_any = 1'b0;
    done_idx = '0;
    for (int k = SLOTS - 1; k >= 0; k--) begin
      if (!busy_vec[k]) begin
        free_any = 1'b1;
        free_idx = IDX_W'(k);
      end
      if (done_vec[k]) begin
        done_any = 1'b1;
        done_idx = IDX_W'(k);
      end
    end
  end

  // Compatibility waits for the whole slot set to drain, using slot zero
  assign slot_ok = compat_on ? (busy_vec == '0) : free_any;
  assign chosen  = compat_on ? '0 : free_idx;
  assign accept  = req_valid_in && req_ready_out;
  assign too_big = req_len_in > limit;
  assign launch  = accept && !too_big;
  // A rejection owns the status port this cycle; finished slots just wait
  assign take_ok = done_any && !(accept && too_big);

  // Slots
  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_slot
      eng_if ei ();
      assign sel[gi]      = launch && (chosen == IDX_W'(gi));
      assign take_vec[gi] = take_ok && (done_idx == IDX_W'(gi));
      assign ei.start     = sel[gi];
      assign ei.bcast     = req_bcast_in;
      assign ei.ack_en    = !req_bcast_in && ack_on;
      assign ei.hdr_en    = hdr_on;
      // Application retries only make sense for unicast with the header
      assign ei.app_en    = !req_bcast_in && hdr_on && (app_retry_count != 8'h00);
      assign ei.frame_id  = req_frame_id_in;
      assign ei.retries   = app_retry_count;
      assign ei.take      = take_vec[gi];
      assign busy_vec[gi] = ei.busy;
      assign done_vec[gi] = ei.done;
      assign did[gi]      = ei.done_id;
      assign dcode[gi]    = ei.code;

      tx_attempt_engine u_eng (
        .mclk_in          (mclk_in),
        .rst_n_in         (rst_n_in),
        .ctl              (ei.eng),
        .link_done_in     (link_done_in[gi]),
        .link_acked_in    (link_acked_in[gi]),
        .link_cca_fail_in (link_cca_fail_in[gi]),
        .net_ack_in       (net_ack_in[gi]),
        .start_out        (tx_start_out[gi]),
        .ack_req_out      (tx_ack_req_out[gi]),
        .app_hdr_out      (tx_app_hdr_out[gi]),
        .bcast_out        (tx_bcast_out[gi])
      );

      bcast_noack_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        tx_start_out[gi] && tx_bcast_out[gi] |-> !tx_ack_req_out[gi])
        else $error("broadcast sent with acknowledgment request");
      mode_ack_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sel[gi] && !req_bcast_in |-> ##2 tx_start_out[gi]
        && (tx_ack_req_out[gi] == !$past(mac_mode_sel[0], 2)))
        else $error("acknowledgment request does not follow MAC mode");
      hdr_mode_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sel[gi] |-> ##2 tx_app_hdr_out[gi]
        == ($past(mac_mode_sel[0], 2) == $past(mac_mode_sel[1], 2)))
        else $error("header insertion does not follow MAC mode");
    end
  endgenerate

  // Acceptance: one request, then at least one idle cycle for busy to settle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= !accept && slot_ok;
    end
  end

  // Status answers; zero identifiers are consumed silently
  assign next_stat_valid = (accept && too_big) ? (req_frame_id_in != 8'h00)
                         : take_ok && (did[done_idx] != 8'h00);
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stat_valid_out    <= 1'b0;
      stat_frame_id_out <= 8'h00;
      stat_code_out     <= ST_OK;
    end else begin
      stat_valid_out <= next_stat_valid;
      if (accept && too_big) begin
        stat_frame_id_out <= req_frame_id_in;
        stat_code_out     <= ST_TOO_BIG;
      end else if (take_ok) begin
        stat_frame_id_out <= did[done_idx];
        stat_code_out     <= dcode[done_idx];
      end
    end
  end

  // Header mode also turns on duplicate filtering at the receive side
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      dup_detect_en_out <= 1'b0;
    end else begin
      dup_detect_en_out <= hdr_on;
    end
  end

  // Settings written by software
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mac_mode_sel    <= MM_RST;
      enc_on          <= ENC_RST;
      app_retry_count <= RR_RST;
      compat_cfg      <= COMPAT_RST;
      irq_en          <= IRQ_EN_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_CFG) begin
        mac_mode_sel <= reg_wdata_in[CFG_MM_LSB +: 2];
        enc_on       <= reg_wdata_in[CFG_ENC_BIT];
      end else if (reg_addr_in == REG_RETRY) begin
        app_retry_count <= reg_wdata_in;
      end else if (reg_addr_in == REG_COMPAT) begin
        compat_cfg <= reg_wdata_in;
      end else if (reg_addr_in == REG_IRQ_EN) begin
        irq_en <= reg_wdata_in[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_STATUS] = next_stat_valid;
    irq_set[IRQ_REJECT] = accept && too_big;
    irq_set[IRQ_FAIL]   = take_ok && (dcode[done_idx] != ST_OK);
    irq_clr = (reg_wr_in && (reg_addr_in == REG_IRQ_CLR)) ? reg_wdata_in[IRQ_W-1:0] : '0;
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_stat <= '0;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_out  <= |(next_irq_stat & irq_en);
    end
  end

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !reg_rd_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_addr_in == REG_CFG) begin
      reg_rdata_out <= {5'h00, enc_on, mac_mode_sel};
    end else if (reg_addr_in == REG_RETRY) begin
      reg_rdata_out <= app_retry_count;
    end else if (reg_addr_in == REG_COMPAT) begin
      reg_rdata_out <= compat_cfg;
    end else if (reg_addr_in == REG_IRQ_STAT) begin
      reg_rdata_out <= 8'(irq_stat);
    end else if (reg_addr_in == REG_IRQ_EN) begin
      reg_rdata_out <= 8'(irq_en);
    end else if (reg_addr_in == REG_STATE) begin
      reg_rdata_out <= 8'({busy_vec, req_ready_out});
    end else begin
      // Unmapped and write-only addresses read zero
      reg_rdata_out <= 8'h00;
    end
  end

  reset_mode_a: assert property (@(posedge mclk_in)
    !rst_n_in |=> (mac_mode_sel == MM_RST) && !stat_valid_out)
    else $error("MAC mode not zero after reset");
  too_big_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    accept && too_big && (req_frame_id_in != 8'h00)
    |=> stat_valid_out && (stat_code_out == ST_TOO_BIG))
    else $error("oversized request not answered with 74");
  compat_lim_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    accept && compat_on && (req_len_in > (enc_on ? COMPAT_ENC : COMPAT_PLAIN))
    |-> !launch) else $error("compatibility limit not applied");
  zero_id_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    stat_valid_out |-> stat_frame_id_out != 8'h00)
    else $error("status sent for zero identifier");
  compat_one_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    accept && compat_on && $past(compat_on) |-> (busy_vec == '0))
    else $error("second packet started in compatibility mode");
  irq_level_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ##1 irq_out == |(irq_stat & $past(irq_en)))
    else $error("interrupt level disagrees with status");

  compat_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    launch && compat_on);
  netack_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    stat_valid_out && (stat_code_out == ST_NETACK));
  reject_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    stat_valid_out && (stat_code_out == ST_TOO_BIG));
  parallel_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
    &busy_vec);
endmodule

// ---- verif/radio_peer_model.sv ----
// Far-side radio model: answers each link attempt after a set delay
`timescale 1ns/1ps
module radio_peer_model #(
  parameter int SLOTS = 2 // Slots watched
) (
  input  wire logic             mclk_in,
  input  wire logic [SLOTS-1:0] start_in,
  input  wire logic [SLOTS-1:0] ack_req_in,
  input  wire logic [1:0]       fate_in,  // 0 reachable, 1 unreachable, 2 busy channel
  input  wire logic [3:0]       delay_in, // Cycles from start to done, at least 1
  output logic      [SLOTS-1:0] done_out,
  output logic      [SLOTS-1:0] acked_out,
  output logic      [SLOTS-1:0] cca_fail_out,
  output logic      [SLOTS-1:0] net_ack_out,
  output int                    attempts_out
);
  logic [3:0] wait_cnt [SLOTS]; // Countdown per slot
  logic       junk;             // Toggles so idle qualifiers carry no stale value
  initial begin
    junk = 1'b0;
    attempts_out = 0;
    done_out = '0;
    for (int s = 0; s < SLOTS; s++) wait_cnt[s] = 4'h0;
  end
  // One answer per attempt; qualifiers only mean something beside done
  always @(posedge mclk_in) begin
    junk <= ~junk;
    attempts_out <= attempts_out + $countones(start_in);
    for (int s = 0; s < SLOTS; s++) begin
      done_out[s] <= (wait_cnt[s] == 4'h1);
      if (start_in[s] === 1'b1) wait_cnt[s] <= delay_in;
      else if (wait_cnt[s] != 4'h0) wait_cnt[s] <= wait_cnt[s] - 4'h1;
      if (wait_cnt[s] == 4'h1) begin
        acked_out[s]    <= ack_req_in[s] && fate_in == 2'h0;
        cca_fail_out[s] <= fate_in == 2'h2;
        net_ack_out[s]  <= fate_in == 2'h0;
      end else begin
        acked_out[s]    <= junk;
        cca_fail_out[s] <= ~junk;
        net_ack_out[s]  <= junk;
      end
    end
  end
endmodule

// ---- verif/tx_retry_status_ctrl_tb.sv ----
// Self-checking bench for the transmit retry and status controller
`timescale 1ns/1ps
module tx_retry_status_ctrl_tb;
  import tx_pkg::*;
  typedef struct {logic [7:0] cfg, rr, comp; logic ls, ld; logic [1:0] fate;
                  logic [7:0] len, code; int att;} row_t;
  logic       mclk, rst_n, rd, wr_s, vld, bc, ls, ld;
  logic [3:0] addr, delay;
  logic [7:0] wd, rdata, id, len, scode, sid, got;
  logic [1:0] fate, start, ackr, hdr, bco, done, acked, cca, nack, mm;
  logic       ready, svld, dup, irq;
  int         errors, n_tests, att, stat_cnt, base, sbase;
  // Length edges, every mode, retry budgets; last column is link attempts
  row_t rows [26] = '{'{0,0,1,0,0,0,100,0,1}, '{0,0,1,0,0,0,101,'h74,0},
    '{4,0,1,0,0,0,95,0,1}, '{4,0,1,0,0,0,96,'h74,0}, '{0,0,0,0,0,0,114,0,1},
    '{0,0,0,0,0,0,115,'h74,0}, '{0,0,0,1,0,0,108,0,1}, '{0,0,0,0,1,0,109,'h74,0},
    '{0,0,0,1,1,0,102,0,1}, '{0,0,0,1,1,0,103,'h74,0}, '{1,0,0,0,0,0,116,0,1},
    '{2,0,0,0,0,0,117,'h74,0}, '{4,0,0,0,0,0,101,0,1}, '{4,0,0,1,0,0,102,'h74,0},
    '{7,0,0,1,1,0,95,0,1}, '{4,0,0,0,1,0,96,'h74,0}, '{6,0,0,0,0,0,105,0,1},
    '{6,0,0,0,1,0,100,'h74,0}, '{0,0,0,0,0,1,10,1,4}, '{0,0,0,0,0,2,10,2,4},
    '{1,0,0,0,0,1,10,0,1}, '{3,0,0,0,0,1,10,0,1}, '{2,0,0,0,0,1,10,1,4},
    '{0,2,0,0,0,1,10,'h21,12}, '{3,2,0,0,0,1,10,'h21,3},
    '{0,1,0,0,0,2,10,2,8}};
  tx_retry_status_ctrl i_tx_retry_status_ctrl (.mclk_in(mclk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .req_valid_in(vld), .req_ready_out(ready), .req_frame_id_in(id),
    .req_len_in(len), .req_bcast_in(bc), .req_long_src_in(ls), .req_long_dst_in(ld),
    .tx_start_out(start), .tx_ack_req_out(ackr), .tx_app_hdr_out(hdr), .tx_bcast_out(bco),
    .link_done_in(done), .link_acked_in(acked), .link_cca_fail_in(cca), .net_ack_in(nack),
    .stat_valid_out(svld), .stat_frame_id_out(sid), .stat_code_out(scode),
    .dup_detect_en_out(dup), .irq_out(irq));
  radio_peer_model i_radio_peer_model (.mclk_in(mclk), .start_in(start), .ack_req_in(ackr),
    .fate_in(fate), .delay_in(delay), .done_out(done), .acked_out(acked),
    .cca_fail_out(cca), .net_ack_out(nack), .attempts_out(att));
  always #12.5 mclk = ~mclk;
  // Status pulses counted, broadcasts watched for an acknowledgment request
  always @(posedge mclk) begin
    if (svld === 1'b1) stat_cnt++;
    for (int s = 0; s < 2; s++) begin
      if (start[s] === 1'b1 && bco[s] === 1'b1) check("bcast ack", 8'h0, {7'h0, ackr[s]});
      // Attributes of each attempt follow the MAC mode last written
      if (start[s] === 1'b1) begin
        check("ack req", {7'h0, !bco[s] && !mm[0]}, {7'h0, ackr[s]});
        check("header", {7'h0, mm[0] ~^ mm[1]}, {7'h0, hdr[s]});
      end
    end
  end
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a; wd <= d; wr_s <= 1'b1;
    if (a == REG_CFG) mm <= d[1:0];
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a; rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 check("register", e, rdata);
  endtask
  // Offers one request and, for a non-zero identifier, waits for its status
  task automatic send(input logic [7:0] fid, flen, input logic b, output logic [7:0] c);
    int n;
    @(posedge mclk);
    vld <= 1'b1; id <= fid; len <= flen; bc <= b;
    n = 0;
    do begin @(posedge mclk); n++; end while (ready !== 1'b1 && n < 200);
    vld <= 1'b0;
    n = 0;
    if (fid != 8'h0) do begin @(posedge mclk); n++; end while (svld !== 1'b1 && n < 400);
    c = (n < 400 && sid === fid) ? scode : 8'hee;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    finish_test;
  end
  initial begin
    {mclk, rst_n, rd, wr_s, vld, bc, ls, ld, addr, wd, id, len} = '0;
    {fate, delay, mm, errors, n_tests, stat_cnt} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(REG_CFG, 8'h00);
    rdc(4'hf, 8'h00);
    check("dup detect", 8'h1, {7'h0, dup});
    for (int i = 0; i < 26; i++) begin
      wr(REG_CFG, rows[i].cfg);
      wr(REG_RETRY, rows[i].rr);
      wr(REG_COMPAT, rows[i].comp);
      ls <= rows[i].ls; ld <= rows[i].ld; fate <= rows[i].fate;
      delay <= i[0] ? 4'h1 : 4'h6;
      base = att;
      send(8'h01 + i[7:0], rows[i].len, 1'b0, got);
      check("status", rows[i].code, got);
      check("attempts", rows[i].att[7:0], 8'(att - base));
      $display("row %0d done", i);
    end
    wr(REG_CFG, 8'h01);
    wr(REG_RETRY, 8'h02);
    fate <= 2'h1;
    send(8'h40, 8'h0a, 1'b0, got);
    check("no header retry", 8'h00, got);
    check("dup off", 8'h0, {7'h0, dup});
    wr(REG_CFG, 8'h00);
    wr(REG_RETRY, 8'h00);
    send(8'h41, 8'h0a, 1'b1, got);
    check("bcast status", 8'h00, got);
    $display("mode test done");
    wr(REG_IRQ_CLR, 8'h07);
    wr(REG_IRQ_EN, 8'h01);
    rdc(REG_IRQ_STAT, 8'h00);
    fate <= 2'h0;
    send(8'h42, 8'h0a, 1'b0, got);
    repeat (2) @(posedge mclk);
    #1 check("irq set", 8'h1, {7'h0, irq});
    wr(REG_IRQ_EN, 8'h00);
    // The interrupt level is registered, so the mask shows one edge later
    @(posedge mclk);
    #1 check("irq masked", 8'h0, {7'h0, irq});
    rdc(REG_IRQ_STAT, 8'h01);
    wr(REG_IRQ_CLR, 8'h01);
    rdc(REG_IRQ_STAT, 8'h00);
    $display("irq test done");
    delay <= 4'hf;
    sbase = stat_cnt;
    base = att;
    send(8'h00, 8'h0a, 1'b0, got);
    repeat (4) @(posedge mclk);
    #1 check("queue ready", 8'h1, {7'h0, ready});
    repeat (40) @(posedge mclk);
    check("silent status", 8'h0, 8'(stat_cnt - sbase));
    check("silent sent", 8'h1, 8'(att - base));
    wr(REG_COMPAT, 8'h01);
    send(8'h00, 8'h0a, 1'b0, got);
    repeat (4) @(posedge mclk);
    #1 check("compat refuse", 8'h0, {7'h0, ready});
    repeat (30) @(posedge mclk);
    $display("queue test done");
    finish_test;
  end
endmodule
